// >>> design/rssc_pkg.sv
// Constants, register map and reset kinds of the reset source and state control.
// Assumes a 32-bit APB slave and an 8-bit core register view.
package rssc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_UV_SEL = 8'h00;
  localparam logic [7:0] OFF_FLASH_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RST_FLAG = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] OFF_CORE_BASE = 8'h20;
  localparam logic [7:0] OFF_CORE_LAST = 8'h3c;

  // Undervoltage filter select
  localparam int UV_CODE_W = 2;
  localparam logic [1:0] UV_SEL_RESET = 2'h1;
  localparam int UV_CNT_W = 8;
  localparam logic [7:0] UV_LIM_CODE0 = 8'h08;
  localparam logic [7:0] UV_LIM_CODE1 = 8'h20;
  localparam logic [7:0] UV_LIM_CODE2 = 8'h40;
  localparam logic [7:0] UV_LIM_CODE3 = 8'h80;

  // Flash control reset key
  localparam logic [7:0] FLASH_RESET_KEY = 8'h55;

  // Status and reset flag register bits
  localparam int STAT_TO_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int RST_BO_BIT = 0;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_BO_BIT = 0;
  localparam int IRQ_WDT_BIT = 1;
  localparam int IRQ_FLASH_BIT = 2;

  // Core register view, one word each from OFF_CORE_BASE
  localparam int CORE_N = 8;
  localparam int CORE_IDX_W = 3;
  localparam int IDX_MP0 = 0;
  localparam int IDX_INDIRECT_ACCESS_ZERO = 1;
  localparam int IDX_INTERRUPT_CONTROL_ZERO = 2;
  localparam int IDX_PORTA = 3;
  localparam int IDX_PCL = 4;
  localparam int IDX_ACC = 5;
  localparam int IDX_TBLP = 6;
  localparam int IDX_SP = 7;
  localparam logic [7:0] STACK_TOP = 8'h07;
  localparam logic [7:0] CORE_ZERO = 8'h00;
  localparam logic [7:0] CORE_INIT [0:CORE_N-1] = '{
    8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h07
  };
  // Registers left untouched by a full reset (accumulator, table pointer)
  localparam logic [CORE_N-1:0] CORE_HOLD = 8'h60;

  typedef enum logic [2:0] {
    RSSC_RST_NONE,
    RSSC_RST_FLASH,
    RSSC_RST_PIN,
    RSSC_RST_PIN_LP,
    RSSC_RST_WDT_RUN,
    RSSC_RST_WDT_LP,
    RSSC_RST_BROWNOUT
  } rssc_rst_t;

endpackage : rssc_pkg

// >>> design/rssc_sticky.sv
// Sticky flag bank: set wins over clear.
// Assumes set and clear are single-cycle pulses on pclk.
`timescale 1ns/1ps
module rssc_sticky #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flag control
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);

  logic [W-1:0] flag_ff;

  // Event in the clear cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= set | (flag_ff & ~clr);
    end
  end

  assign q = flag_ff;

endmodule : rssc_sticky

// >>> design/rssc_top.sv
// Reset source and state control: reset sources, flags and core state.
// Assumes an APB master on pclk and synchronous event inputs.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module rssc_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources
  input wire logic external_pin_clear,
  input wire logic watchdog_expire,
  input wire logic brownout_detector,
  input wire logic subclock_tick,
  // Core mode
  input wire logic low_power_mode,
  input wire logic enter_low_power,
  // Reset actions
  output logic core_reset,
  output logic wdt_timebase_clear,
  output logic timers_off,
  output logic ports_to_input,
  // Core state
  output logic [7:0] memory_pointer_zero,
  output logic [7:0] indirect_access_zero,
  output logic [7:0] interrupt_control_zero,
  output logic [7:0] port_a_data,
  output logic [7:0] program_counter_low,
  output logic [7:0] accumulator,
  output logic [7:0] table_pointer,
  output logic [7:0] stack_pointer,
  // Interrupt
  output logic irq
);

  rssc_pkg::rssc_rst_t kind;
  logic wr_acc;
  logic rd_setup;
  logic flash_hit;
  logic bo_fire;
  logic core_hit;
  logic [rssc_pkg::CORE_IDX_W-1:0] core_idx;
  logic mapped;
  logic full_init;
  logic [rssc_pkg::UV_CODE_W-1:0] undervolt_filter_select_ff;
  logic [7:0] flash_ctrl_one_ff;
  logic watchdog_timeout_flag_ff;
  logic powerdown_flag_ff;
  logic [rssc_pkg::IRQ_W-1:0] irq_en_ff;
  logic [rssc_pkg::IRQ_W-1:0] irq_set;
  logic [rssc_pkg::IRQ_W-1:0] irq_clr;
  logic [rssc_pkg::IRQ_W-1:0] irq_stat;
  logic brownout_flag;
  logic bo_flag_clr;
  logic [7:0] core_ff [0:rssc_pkg::CORE_N-1];
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic core_reset_ff;
  logic init_ff;

  // APB decode
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign core_hit = (paddr >= rssc_pkg::OFF_CORE_BASE) && (paddr <= rssc_pkg::OFF_CORE_LAST)
                    && (paddr[1:0] == 2'h0);
  assign core_idx = paddr[4:2];
  assign mapped = core_hit
                  || (paddr == rssc_pkg::OFF_UV_SEL)
                  || (paddr == rssc_pkg::OFF_FLASH_CTRL)
                  || (paddr == rssc_pkg::OFF_STATUS)
                  || (paddr == rssc_pkg::OFF_RST_FLAG)
                  || (paddr == rssc_pkg::OFF_IRQ_STAT)
                  || (paddr == rssc_pkg::OFF_IRQ_CLR)
                  || (paddr == rssc_pkg::OFF_IRQ_EN);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;

  assign flash_hit = wr_acc && (paddr == rssc_pkg::OFF_FLASH_CTRL)
                     && (pwdata[7:0] == rssc_pkg::FLASH_RESET_KEY);

  rssc_uv_filter u_uv_filter (
    .pclk(pclk),
    .presetn(presetn),
    .undervolt(brownout_detector),
    .sub_tick(subclock_tick),
    .undervolt_duration_code(undervolt_filter_select_ff),
    .fire(bo_fire)
  );

  // Reset kind, whole-device sources first
  always_comb begin
    if (flash_hit) begin
      kind = rssc_pkg::RSSC_RST_FLASH;
    end else if (external_pin_clear) begin
      kind = low_power_mode ? rssc_pkg::RSSC_RST_PIN_LP : rssc_pkg::RSSC_RST_PIN;
    end else if (watchdog_expire) begin
      kind = low_power_mode ? rssc_pkg::RSSC_RST_WDT_LP : rssc_pkg::RSSC_RST_WDT_RUN;
    end else if (bo_fire) begin
      kind = rssc_pkg::RSSC_RST_BROWNOUT;
    end else begin
      kind = rssc_pkg::RSSC_RST_NONE;
    end
  end

  assign full_init = (kind == rssc_pkg::RSSC_RST_FLASH) || (kind == rssc_pkg::RSSC_RST_PIN)
                     || (kind == rssc_pkg::RSSC_RST_PIN_LP)
                     || (kind == rssc_pkg::RSSC_RST_WDT_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undervolt_filter_select_ff <= rssc_pkg::UV_SEL_RESET;
    end else if (kind == rssc_pkg::RSSC_RST_FLASH) begin
      undervolt_filter_select_ff <= rssc_pkg::UV_SEL_RESET;
    end else if (wr_acc && (paddr == rssc_pkg::OFF_UV_SEL)) begin
      undervolt_filter_select_ff <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ctrl_one_ff <= 8'h00;
    end else if (wr_acc && (paddr == rssc_pkg::OFF_FLASH_CTRL)) begin
      flash_ctrl_one_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b0;
    end else begin
      unique case (kind)
        rssc_pkg::RSSC_RST_WDT_RUN: begin
          watchdog_timeout_flag_ff <= 1'b1;
        end
        rssc_pkg::RSSC_RST_WDT_LP: begin
          watchdog_timeout_flag_ff <= 1'b1;
          powerdown_flag_ff <= 1'b1;
        end
        rssc_pkg::RSSC_RST_PIN_LP: begin
          watchdog_timeout_flag_ff <= 1'b0;
          powerdown_flag_ff <= 1'b1;
        end
        rssc_pkg::RSSC_RST_PIN, rssc_pkg::RSSC_RST_BROWNOUT, rssc_pkg::RSSC_RST_FLASH: begin
        end
        rssc_pkg::RSSC_RST_NONE: begin
          if (enter_low_power) begin
            powerdown_flag_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // brownout flag, software zero write clears
  assign bo_flag_clr = wr_acc && (paddr == rssc_pkg::OFF_RST_FLAG)
                       && !pwdata[rssc_pkg::RST_BO_BIT];

  rssc_sticky #(.W(1)) u_bo_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(kind == rssc_pkg::RSSC_RST_BROWNOUT),
    .clr(bo_flag_clr),
    .q(brownout_flag)
  );

  // Interrupt status, clear and enable
  always_comb begin
    irq_set = '0;
    irq_set[rssc_pkg::IRQ_BO_BIT] = (kind == rssc_pkg::RSSC_RST_BROWNOUT);
    irq_set[rssc_pkg::IRQ_WDT_BIT] = (kind == rssc_pkg::RSSC_RST_WDT_RUN)
                                     || (kind == rssc_pkg::RSSC_RST_WDT_LP);
    irq_set[rssc_pkg::IRQ_FLASH_BIT] = (kind == rssc_pkg::RSSC_RST_FLASH);
  end

  assign irq_clr = (wr_acc && (paddr == rssc_pkg::OFF_IRQ_CLR)) ? pwdata[2:0] : '0;

  rssc_sticky #(.W(rssc_pkg::IRQ_W)) u_irq_stat (
    .pclk(pclk),
    .presetn(presetn),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_stat)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= '0;
    end else if (wr_acc && (paddr == rssc_pkg::OFF_IRQ_EN)) begin
      irq_en_ff <= pwdata[2:0];
    end
  end

  assign irq = |(irq_stat & irq_en_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < rssc_pkg::CORE_N; i++) begin
        core_ff[i] <= rssc_pkg::CORE_INIT[i];
      end
    end else begin
      for (int i = 0; i < rssc_pkg::CORE_N; i++) begin
        // PC low cleared on any reset
        if (kind != rssc_pkg::RSSC_RST_NONE && i == rssc_pkg::IDX_PCL) begin
          core_ff[i] <= rssc_pkg::CORE_ZERO;
        // low-power watchdog clears only the stack pointer and PC low
        end else if (kind == rssc_pkg::RSSC_RST_WDT_LP && i == rssc_pkg::IDX_SP) begin
          core_ff[i] <= rssc_pkg::CORE_ZERO;
        // full reset reinitialises, holds kept ones
        end else if (full_init && !rssc_pkg::CORE_HOLD[i]) begin
          core_ff[i] <= rssc_pkg::CORE_INIT[i];
        end else if (kind == rssc_pkg::RSSC_RST_NONE && wr_acc && core_hit
                     && core_idx == i[2:0]) begin
          core_ff[i] <= pwdata[7:0];
        end
      end
    end
  end

  assign memory_pointer_zero = core_ff[rssc_pkg::IDX_MP0];
  assign indirect_access_zero = core_ff[rssc_pkg::IDX_INDIRECT_ACCESS_ZERO];
  assign interrupt_control_zero = core_ff[rssc_pkg::IDX_INTERRUPT_CONTROL_ZERO];
  assign port_a_data = core_ff[rssc_pkg::IDX_PORTA];
  assign program_counter_low = core_ff[rssc_pkg::IDX_PCL];
  assign accumulator = core_ff[rssc_pkg::IDX_ACC];
  assign table_pointer = core_ff[rssc_pkg::IDX_TBLP];
  assign stack_pointer = core_ff[rssc_pkg::IDX_SP];

  // init pulse after power-on release
  // Also issued on full resets so timers and ports match power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_ff <= 1'b1;
      core_reset_ff <= 1'b0;
    end else begin
      init_ff <= full_init;
      core_reset_ff <= (kind != rssc_pkg::RSSC_RST_NONE);
    end
  end

  assign core_reset = core_reset_ff;
  assign wdt_timebase_clear = init_ff;
  assign timers_off = init_ff;
  assign ports_to_input = init_ff;

  // Read mux, captured in setup so prdata is a flop
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (core_hit) begin
      nxt_prdata[7:0] = core_ff[core_idx];
    end else begin
      unique case (paddr)
        rssc_pkg::OFF_UV_SEL: nxt_prdata[1:0] = undervolt_filter_select_ff;
        rssc_pkg::OFF_FLASH_CTRL: nxt_prdata[7:0] = flash_ctrl_one_ff;
        rssc_pkg::OFF_STATUS: begin
          nxt_prdata[rssc_pkg::STAT_TO_BIT] = watchdog_timeout_flag_ff;
          nxt_prdata[rssc_pkg::STAT_PD_BIT] = powerdown_flag_ff;
        end
        rssc_pkg::OFF_RST_FLAG: nxt_prdata[rssc_pkg::RST_BO_BIT] = brownout_flag;
        rssc_pkg::OFF_IRQ_STAT: nxt_prdata[2:0] = irq_stat;
        rssc_pkg::OFF_IRQ_EN: nxt_prdata[2:0] = irq_en_ff;
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

endmodule : rssc_top

// >>> design/rssc_uv_filter.sv
// Undervoltage width filter counting subclock ticks.
// Assumes undervolt level and sub_tick pulses are synchronous to pclk.
`timescale 1ns/1ps
module rssc_uv_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Detector side
  input wire logic undervolt,
  input wire logic sub_tick,
  input wire logic [rssc_pkg::UV_CODE_W-1:0] undervolt_duration_code,
  // Reset request
  output logic fire
);

  logic [rssc_pkg::UV_CNT_W-1:0] cnt_ff;
  logic fired_ff;
  logic fire_ff;
  logic [rssc_pkg::UV_CNT_W-1:0] lim;
  logic [rssc_pkg::UV_CNT_W-1:0] nxt_cnt;

  always_comb begin
    unique case (undervolt_duration_code)
      2'h0: lim = rssc_pkg::UV_LIM_CODE0;
      2'h1: lim = rssc_pkg::UV_LIM_CODE1;
      2'h2: lim = rssc_pkg::UV_LIM_CODE2;
      2'h3: lim = rssc_pkg::UV_LIM_CODE3;
    endcase
  end

  assign nxt_cnt = cnt_ff + 8'h01;

  // fire only after full width
  // Tick phase makes the real width N-1 to N subclock periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      fired_ff <= 1'b0;
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= 1'b0;
      if (!undervolt) begin
        cnt_ff <= '0;
        fired_ff <= 1'b0;
      end else if (sub_tick && !fired_ff) begin
        cnt_ff <= nxt_cnt;
        if (nxt_cnt >= lim) begin
          fire_ff <= 1'b1;
          fired_ff <= 1'b1;
        end
      end
    end
  end

  assign fire = fire_ff;

endmodule : rssc_uv_filter

// >>> tb/rssc_checker.sv
// Port assertions for the reset source and state control.
// Assumes binding to rssc_top; sees only its ports.
`timescale 1ns/1ps
module rssc_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and sources
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic external_pin_clear,
  input wire logic watchdog_expire,
  input wire logic brownout_detector,
  input wire logic subclock_tick,
  input wire logic low_power_mode,
  // Observed outputs
  input wire logic core_reset,
  input wire logic wdt_timebase_clear,
  input wire logic timers_off,
  input wire logic ports_to_input,
  input wire logic [7:0] memory_pointer_zero,
  input wire logic [7:0] interrupt_control_zero,
  input wire logic [7:0] port_a_data,
  input wire logic [7:0] program_counter_low,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] stack_pointer
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire logic flash_wr = psel && penable && pwrite && paddr == rssc_pkg::OFF_FLASH_CTRL
    && pwdata[7:0] == rssc_pkg::FLASH_RESET_KEY;
  wire logic src = flash_wr || external_pin_clear || watchdog_expire;
  wire logic full_rst = flash_wr || external_pin_clear || (watchdog_expire && !low_power_mode);
  wire logic lp_wdt = watchdog_expire && low_power_mode && !external_pin_clear && !flash_wr;
  // Filter delay is a few edges, so allow two
  wire logic bo_tick = brownout_detector && subclock_tick;

  AST_FLASH_RST: assert property (flash_wr |=> core_reset && memory_pointer_zero == 8'h00)
    else $error("flash key write gave no full reset");
  AST_WDT_RUN: assert property (watchdog_expire && !low_power_mode |=> core_reset
    && port_a_data == 8'hff && $stable(accumulator))
    else $error("running watchdog reset wrong");
  AST_WDT_LP: assert property (lp_wdt |=> stack_pointer == 8'h00
    && program_counter_low == 8'h00 && $stable(memory_pointer_zero) && $stable(port_a_data))
    else $error("low power watchdog reset wrong");
  AST_PIN_FULL: assert property (external_pin_clear && !low_power_mode |=> core_reset
    && memory_pointer_zero == 8'h00 && interrupt_control_zero == 8'h00 && port_a_data == 8'hff)
    else $error("pin reset state wrong");
  AST_INIT_PULSE: assert property (!$past(presetn) |-> wdt_timebase_clear
    && timers_off && ports_to_input)
    else $error("init pulses missing after power on");
  AST_POR_STATE: assert property (!$past(presetn) |-> stack_pointer == rssc_pkg::STACK_TOP
    && program_counter_low == 8'h00 && interrupt_control_zero == 8'h00)
    else $error("power on core state wrong");
  AST_TIMERS_CAUSE: assert property (timers_off && $past(presetn) |-> $past(full_rst))
    else $error("timers off without full reset");
  AST_BO_CAUSE: assert property (core_reset && !$past(src) |->
    $past(bo_tick, 2) || $past(bo_tick, 3))
    else $error("core reset without brownout tick");
endmodule : rssc_checker

bind rssc_top rssc_checker i_rssc_checker (.*);

// >>> tb/tb_top.sv
// Self-checking bench for rssc_top: APB, reset sources, flags.
// Assumes a 200 MHz pclk and the register map of rssc_pkg.
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic external_pin_clear = 1'b0, watchdog_expire = 1'b0, brownout_detector = 1'b0;
  logic subclock_tick = 1'b0, low_power_mode = 1'b0, enter_low_power = 1'b0;
  logic pready, pslverr, core_reset, wdt_timebase_clear, timers_off, ports_to_input, irq;
  logic [7:0] memory_pointer_zero, indirect_access_zero, interrupt_control_zero, port_a_data;
  logic [7:0] program_counter_low, accumulator, table_pointer, stack_pointer;
  int num_errors = 0, tests_run = 0, rst_seen = 0;
  logic slverr_seen = 1'b0;

  rssc_top i_rssc_top (.*);

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (core_reset === 1'b1)
      rst_seen <= rst_seen + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    slverr_seen = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd

  function automatic logic [7:0] ca(input int i);
    return 8'(rssc_pkg::OFF_CORE_BASE + 4 * i);
  endfunction : ca

  // Order of bits: pin, watchdog, sleep entry
  task automatic pulse(input logic [2:0] k);
    @(posedge pclk);
    {external_pin_clear, watchdog_expire, enter_low_power} <= k;
    @(posedge pclk);
    {external_pin_clear, watchdog_expire, enter_low_power} <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  task automatic tick();
    @(posedge pclk);
    subclock_tick <= 1'b1;
    @(posedge pclk);
    subclock_tick <= 1'b0;
  endtask : tick

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task automatic t_por();
    chk("sp", 32'(rssc_pkg::STACK_TOP), 32'(stack_pointer));
    chk("pcl", 32'h0, 32'(program_counter_low));
    chk("intc", 32'h0, 32'(interrupt_control_zero));
    chk("porta", 32'hff, 32'(port_a_data));
    chk("mp0", 32'h0, 32'(memory_pointer_zero));
    chk("indirect_access_zero", 32'h0, 32'(indirect_access_zero));
    rd("uv_sel", rssc_pkg::OFF_UV_SEL, 32'h1);
    chk("pslverr_mapped", 32'h0, 32'(slverr_seen));
    wr(rssc_pkg::OFF_UV_SEL, 32'hffff_ffff);
    rd("uv_sel", rssc_pkg::OFF_UV_SEL, 32'h3);
    wr(rssc_pkg::OFF_STATUS, 32'h3);
    rd("status", rssc_pkg::OFF_STATUS, 32'h0);
    rd("unmapped", 8'h40, 32'h0);
    chk("pslverr_unmapped", 32'h1, 32'(slverr_seen));
  endtask : t_por

  task automatic t_flash();
    int s;
    wr(ca(rssc_pkg::IDX_ACC), 32'h5a);
    wr(ca(rssc_pkg::IDX_MP0), 32'h33);
    wr(ca(rssc_pkg::IDX_TBLP), 32'h66);
    wr(ca(rssc_pkg::IDX_INDIRECT_ACCESS_ZERO), 32'h21);
    s = rst_seen;
    wr(rssc_pkg::OFF_FLASH_CTRL, 32'h54);
    repeat (3) @(posedge pclk);
    chk("no_reset", 32'(s), 32'(rst_seen));
    wr(rssc_pkg::OFF_FLASH_CTRL, 32'h55);
    repeat (3) @(posedge pclk);
    chk("reset", 32'(s + 1), 32'(rst_seen));
    chk("mp0", 32'h0, 32'(memory_pointer_zero));
    rd("acc", ca(rssc_pkg::IDX_ACC), 32'h5a);
    chk("tblp", 32'h66, 32'(table_pointer));
    chk("indirect_access_zero", 32'h0, 32'(indirect_access_zero));
    rd("irq_stat", rssc_pkg::OFF_IRQ_STAT, 32'h4);
    wr(rssc_pkg::OFF_IRQ_CLR, 32'h7);
  endtask : t_flash

  task automatic t_flags();
    pulse(3'b001);
    rd("status", rssc_pkg::OFF_STATUS, 32'h2);
    pulse(3'b100);
    rd("status", rssc_pkg::OFF_STATUS, 32'h2);
    pulse(3'b010);
    rd("status", rssc_pkg::OFF_STATUS, 32'h3);
    do_reset();
    rd("status", rssc_pkg::OFF_STATUS, 32'h0);
    wr(ca(rssc_pkg::IDX_MP0), 32'h44);
    wr(ca(rssc_pkg::IDX_PCL), 32'h12);
    low_power_mode <= 1'b1;
    pulse(3'b010);
    low_power_mode <= 1'b0;
    rd("status", rssc_pkg::OFF_STATUS, 32'h3);
    chk("sp", 32'h0, 32'(stack_pointer));
    chk("pcl", 32'h0, 32'(program_counter_low));
    chk("mp0", 32'h44, 32'(memory_pointer_zero));
  endtask : t_flags

  task automatic t_bo();
    int lim[4] = '{8, 32, 64, 128};
    int s;
    wr(rssc_pkg::OFF_IRQ_EN, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(rssc_pkg::OFF_UV_SEL, 32'(c));
      brownout_detector <= 1'b1;
      s = rst_seen;
      repeat (lim[c] - 1) tick();
      repeat (4) @(posedge pclk);
      chk("early", 32'(s), 32'(rst_seen));
      tick();
      repeat (4) @(posedge pclk);
      chk("fired", 32'(s + 1), 32'(rst_seen));
      brownout_detector <= 1'b0;
    end
    chk("mp0", 32'h44, 32'(memory_pointer_zero));
    rd("status", rssc_pkg::OFF_STATUS, 32'h3);
    chk("irq", 32'h1, 32'(irq));
    wr(rssc_pkg::OFF_IRQ_EN, 32'h0);
    @(posedge pclk);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(rssc_pkg::OFF_RST_FLAG, 32'h1);
    rd("bo_flag", rssc_pkg::OFF_RST_FLAG, 32'h1);
    wr(rssc_pkg::OFF_RST_FLAG, 32'h0);
    rd("bo_flag", rssc_pkg::OFF_RST_FLAG, 32'h0);
    wr(rssc_pkg::OFF_IRQ_EN, 32'h1);
    @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    wr(rssc_pkg::OFF_IRQ_CLR, 32'h1);
    @(posedge pclk);
    chk("irq_clr", 32'h0, 32'(irq));
  endtask : t_bo

  // Pin reset while asleep: full core init, timeout cleared, powerdown set
  task automatic t_lp_pin();
    wr(ca(rssc_pkg::IDX_PORTA), 32'h0f);
    rd("porta_wr", ca(rssc_pkg::IDX_PORTA), 32'h0f);
    low_power_mode <= 1'b1;
    pulse(3'b100);
    low_power_mode <= 1'b0;
    rd("status_lp_pin", rssc_pkg::OFF_STATUS, 32'h2);
    chk("mp0", 32'h0, 32'(memory_pointer_zero));
    chk("porta", 32'hff, 32'(port_a_data));
    chk("pcl", 32'h0, 32'(program_counter_low));
  endtask : t_lp_pin

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_por();
    t_flash();
    t_flags();
    t_bo();
    t_lp_pin();
    report_and_stop();
  end

  // Hang guard well beyond the longest scenario
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule : tb_top
